//--- src/coe_pkg.sv
// Purpose: shared constants for the clock output enable control block
// Assumes: 16-bit registers in the low half of 32-bit bus words
// Notes: byte address is four times the register index
package coe_pkg;
  // Register indices and byte addresses
  localparam logic [7:0] IDX_DIS = 8'h03;
  localparam logic [7:0] IDX_FMT = 8'h06;
  localparam logic [7:0] IDX_OE = 8'h07;
  localparam logic [7:0] IDX_AUX = 8'h10;
  localparam logic [7:0] IDX_STAT = 8'h11;
  localparam logic [7:0] ADR_DIS = {IDX_DIS[5:0], 2'h0};
  localparam logic [7:0] ADR_FMT = {IDX_FMT[5:0], 2'h0};
  localparam logic [7:0] ADR_OE = {IDX_OE[5:0], 2'h0};
  localparam logic [7:0] ADR_AUX = {IDX_AUX[5:0], 2'h0};
  localparam logic [7:0] ADR_STAT = {IDX_STAT[5:0], 2'h0};
  // Field positions
  localparam int DIS_A_BIT = 5;
  localparam int DIS_B_BIT = 6;
  localparam int FMT_A_LSB = 0;
  localparam int SLEW_A_LSB = 3;
  localparam int POL_BIT = 0;
  localparam int EN_A_BIT = 1;
  localparam int FMT_B_LSB = 2;
  localparam int SLEW_B_LSB = 5;
  localparam int EN_B_BIT = 8;
  localparam int FUNC_LSB = 13;
  // Writable bit masks, everything else is kept
  localparam logic [15:0] MASK_DIS = 16'h0060;
  localparam logic [15:0] MASK_FMT = 16'h001F;
  localparam logic [15:0] MASK_OE = 16'h617F;
  localparam logic [15:0] MASK_AUX = 16'h0007;
  // Fused start-up pages, fixed contents
  localparam logic [3:0][15:0] PAGE_DIS = {4{16'h0000}};
  localparam logic [3:0][15:0] PAGE_FMT = {4{16'h0000}};
  localparam logic [3:0][15:0] PAGE_OE = {4{16'h6103}};
  // Timing counts
  localparam logic [1:0] SYNC_CYCLES = 2'h3;
  localparam logic [3:0] READY_TICKS = 4'h8;
  // Bus address upper bits and bus responses
  localparam logic [4:0] DEV_ADDR_HI = 5'h1A;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Multipurpose pin function
  typedef enum logic [1:0] {
    FN_LOW = 2'h0, FN_HIZ = 2'h1, FN_AUX = 2'h2, FN_READY = 2'h3
  } coe_func_e;
  // Start-up sequence, Gray along the path
  typedef enum logic [1:0] {
    ST_WAIT = 2'h0, ST_SAMPLE = 2'h1, ST_LOAD = 2'h3, ST_RUN = 2'h2
  } coe_state_e;
endpackage

//--- src/coe_clock_output_ctrl.sv
// Purpose: start-up mode, pin function and glitch-free output enables
// Assumes: divider ticks are one-cycle pulses on ref_clk
// Notes: registers reached over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module coe_clock_output_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // AXI4-Lite write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Divider ticks
  input wire logic fractional_divider_a_tick,
  input wire logic fractional_divider_b_tick,
  // Multipurpose pin
  input wire logic ctrl_pin_i,
  output logic ctrl_pin_o,
  output logic ctrl_pin_oe,
  // Enable pin and its pulls
  input wire logic oe_pin_i,
  output logic oe_pull_up_en,
  output logic oe_pull_down_en,
  // Straps
  input wire logic [1:0] page_select_pins,
  input wire logic [1:0] format_address_strap,
  // Clock outputs
  output logic first_clock_output_o,
  output logic first_clock_output_oe,
  output logic second_clock_output_o,
  output logic second_clock_output_oe,
  // Output stage settings and status
  output logic [2:0] format_a,
  output logic [1:0] slew_a,
  output logic [2:0] format_b,
  output logic [1:0] slew_b,
  output logic serial_mode,
  output logic [6:0] bus_address
);
  // Pin synchronisers
  logic mode_s1, mode_s2, en_s1, en_s2;
  logic [1:0] page_s1, page_s2, strap_s1, strap_s2;
  always_ff @(posedge ref_clk) begin
    mode_s1 <= ctrl_pin_i;
    mode_s2 <= mode_s1;
    en_s1 <= oe_pin_i;
    en_s2 <= en_s1;
    page_s1 <= page_select_pins;
    page_s2 <= page_s1;
    strap_s1 <= format_address_strap;
    strap_s2 <= strap_s1;
  end

  // Masked 16-bit write with byte strobes
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                       input logic [3:0] s, input logic [15:0] m);
    logic [15:0] be;
    be = {{8{s[1]}}, {8{s[0]}}} & m;
    wr16 = (old & ~be) | (d[15:0] & be);
  endfunction

  // Enable gating step: changes only while the clock is low
  function automatic logic [1:0] gate_step(input logic clk, input logic run,
                                           input logic want, input logic tick);
    gate_step = {clk, run};
    if (tick && clk) gate_step = {1'b0, run};
    else if (tick) gate_step = {want, want};
  endfunction

  // Start-up state
  coe_pkg::coe_state_e state_reg, state_next;
  logic [1:0] wait_reg, wait_next, page_reg, page_next, strap_reg, strap_next;
  logic serial_reg, serial_next;
  logic running;
  assign running = (state_reg == coe_pkg::ST_RUN);

  // Start-up sequencing and strap capture
  always_comb begin
    state_next = state_reg;
    wait_next = wait_reg;
    page_next = page_reg;
    strap_next = strap_reg;
    serial_next = serial_reg;
    case (state_reg)
      coe_pkg::ST_WAIT: begin
        wait_next = wait_reg + 2'h1;
        if (wait_reg == coe_pkg::SYNC_CYCLES) state_next = coe_pkg::ST_SAMPLE;
      end
      coe_pkg::ST_SAMPLE: begin
        serial_next = !mode_s2;
        page_next = mode_s2 ? page_s2 : 2'h0;
        strap_next = strap_s2;
        state_next = coe_pkg::ST_LOAD;
      end
      coe_pkg::ST_LOAD: state_next = coe_pkg::ST_RUN;
      coe_pkg::ST_RUN: state_next = coe_pkg::ST_RUN;
      default: state_next = coe_pkg::ST_WAIT;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_reg <= coe_pkg::ST_WAIT;
      wait_reg <= 2'h0;
      page_reg <= 2'h0;
      strap_reg <= 2'h0;
      serial_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      page_reg <= page_next;
      strap_reg <= strap_next;
      serial_reg <= serial_next;
    end
  end

  // Bus slave state
  logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next, rdata_reg, rdata_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic wr_fire, mapped_w, mapped_r;
  logic [15:0] dis_reg, dis_next, fmt_reg, fmt_next, oe_reg, oe_next;
  logic [15:0] aux_reg, aux_next, stat_word;
  logic clk_a_reg, run_a_reg, clk_b_reg, run_b_reg, ready_reg, b_seen_reg;
  logic [3:0] tick_cnt_reg;

  assign awready = !aw_hold_reg && !bvalid_reg;
  assign wready = !w_hold_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign mapped_w = aw_addr_reg inside {coe_pkg::ADR_DIS, coe_pkg::ADR_FMT,
                                       coe_pkg::ADR_OE, coe_pkg::ADR_AUX, coe_pkg::ADR_STAT};
  assign mapped_r = araddr inside {coe_pkg::ADR_DIS, coe_pkg::ADR_FMT,
                                  coe_pkg::ADR_OE, coe_pkg::ADR_AUX, coe_pkg::ADR_STAT};
  assign bus_address = {coe_pkg::DEV_ADDR_HI, strap_reg};
  assign stat_word = {1'b0, bus_address, 1'b0, en_s2, run_b_reg, run_a_reg,
                      page_reg, serial_reg, ready_reg};

  // Channel handshakes and answers
  always_comb begin
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next = w_hold_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (awvalid && awready) begin
      aw_hold_next = 1'b1;
      aw_addr_next = awaddr;
    end
    if (wvalid && wready) begin
      w_hold_next = 1'b1;
      w_data_next = wdata;
      w_strb_next = wstrb;
    end
    if (wr_fire) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = mapped_w ? coe_pkg::RESP_OKAY : coe_pkg::RESP_SLVERR;
    end else if (bvalid_reg && bready) bvalid_next = 1'b0;
    if (arvalid && arready) begin
      rvalid_next = 1'b1;
      rresp_next = mapped_r ? coe_pkg::RESP_OKAY : coe_pkg::RESP_SLVERR;
      case (araddr)
        coe_pkg::ADR_DIS: rdata_next = {16'h0000, dis_reg};
        coe_pkg::ADR_FMT: rdata_next = {16'h0000, fmt_reg};
        coe_pkg::ADR_OE: rdata_next = {16'h0000, oe_reg};
        coe_pkg::ADR_AUX: rdata_next = {16'h0000, aux_reg};
        coe_pkg::ADR_STAT: rdata_next = {16'h0000, stat_word};
        default: rdata_next = 32'h00000000;
      endcase
    end else if (rvalid_reg && rready) rvalid_next = 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg <= w_hold_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // Live configuration: page load, then masked writes
  always_comb begin
    dis_next = dis_reg;
    fmt_next = fmt_reg;
    oe_next = oe_reg;
    aux_next = aux_reg;
    if (state_reg == coe_pkg::ST_LOAD) begin
      dis_next = coe_pkg::PAGE_DIS[page_reg];
      fmt_next = coe_pkg::PAGE_FMT[page_reg];
      oe_next = coe_pkg::PAGE_OE[page_reg];
    end else if (wr_fire && running) begin
      case (aw_addr_reg)
        coe_pkg::ADR_DIS: dis_next = wr16(dis_reg, w_data_reg, w_strb_reg, coe_pkg::MASK_DIS);
        coe_pkg::ADR_FMT: fmt_next = wr16(fmt_reg, w_data_reg, w_strb_reg, coe_pkg::MASK_FMT);
        coe_pkg::ADR_OE: oe_next = wr16(oe_reg, w_data_reg, w_strb_reg, coe_pkg::MASK_OE);
        coe_pkg::ADR_AUX: aux_next = wr16(aux_reg, w_data_reg, w_strb_reg, coe_pkg::MASK_AUX);
        default: aux_next = aux_reg;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      dis_reg <= coe_pkg::PAGE_DIS[0];
      fmt_reg <= coe_pkg::PAGE_FMT[0];
      oe_reg <= coe_pkg::PAGE_OE[0];
      aux_reg <= 16'h0000;
    end else begin
      dis_reg <= dis_next;
      fmt_reg <= fmt_next;
      oe_reg <= oe_next;
      aux_reg <= aux_next;
    end
  end

  // Output stage settings
  assign format_a = fmt_reg[coe_pkg::FMT_A_LSB +: 3];
  assign slew_a = fmt_reg[coe_pkg::SLEW_A_LSB +: 2];
  assign format_b = oe_reg[coe_pkg::FMT_B_LSB +: 3];
  assign slew_b = oe_reg[coe_pkg::SLEW_B_LSB +: 2];
  assign serial_mode = serial_reg;
  assign oe_pull_down_en = oe_reg[coe_pkg::POL_BIT];
  assign oe_pull_up_en = !oe_reg[coe_pkg::POL_BIT];

  // Enable decode
  logic en_asserted, want_a, want_b, aux_tick;
  coe_pkg::coe_func_e func;
  assign en_asserted = oe_reg[coe_pkg::POL_BIT] ? !en_s2 : en_s2;
  assign want_a = running && en_asserted && oe_reg[coe_pkg::EN_A_BIT];
  assign want_b = running && en_asserted && oe_reg[coe_pkg::EN_B_BIT];
  assign func = coe_pkg::coe_func_e'(oe_reg[coe_pkg::FUNC_LSB +: 2]);
  assign aux_tick = aux_reg[0] ? fractional_divider_b_tick : fractional_divider_a_tick;

  // Output clocks, aux divider, ready and pin drive
  logic clk_a_next, run_a_next, clk_b_next, run_b_next, aux_clk_reg, aux_clk_next;
  logic [1:0] aux_cnt_reg, aux_cnt_next, aux_lim;
  logic [3:0] tick_cnt_next;
  logic ready_next, b_seen_next, pin_o_reg, pin_o_next, pin_oe_reg, pin_oe_next;
  always_comb begin
    {clk_a_next, run_a_next} = gate_step(clk_a_reg, run_a_reg, want_a,
                                         fractional_divider_a_tick);
    {clk_b_next, run_b_next} = gate_step(clk_b_reg, run_b_reg, want_b,
                                         fractional_divider_b_tick);
    aux_lim = (aux_reg[2:1] == 2'h0) ? 2'h0 : (aux_reg[2:1] == 2'h1) ? 2'h1 : 2'h3;
    aux_clk_next = 1'b0;
    aux_cnt_next = 2'h0;
    if (running && func == coe_pkg::FN_AUX) begin
      aux_clk_next = aux_clk_reg;
      aux_cnt_next = aux_cnt_reg;
      if (aux_tick && aux_cnt_reg == aux_lim) begin
        aux_clk_next = !aux_clk_reg;
        aux_cnt_next = 2'h0;
      end else if (aux_tick) aux_cnt_next = aux_cnt_reg + 2'h1;
    end
    tick_cnt_next = 4'h0;
    b_seen_next = 1'b0;
    if (running) begin
      tick_cnt_next = tick_cnt_reg;
      if (fractional_divider_a_tick && tick_cnt_reg != coe_pkg::READY_TICKS)
        tick_cnt_next = tick_cnt_reg + 4'h1;
      b_seen_next = b_seen_reg || fractional_divider_b_tick;
    end
    ready_next = (tick_cnt_reg == coe_pkg::READY_TICKS) && b_seen_reg;
    pin_o_next = 1'b0;
    pin_oe_next = 1'b0;
    if (running) begin
      case (func)
        coe_pkg::FN_LOW: pin_oe_next = 1'b1;
        coe_pkg::FN_HIZ: pin_oe_next = 1'b0;
        coe_pkg::FN_AUX: begin
          pin_oe_next = 1'b1;
          pin_o_next = aux_clk_reg;
        end
        default: begin
          pin_oe_next = 1'b1;
          pin_o_next = ready_reg;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      clk_a_reg <= 1'b0;
      run_a_reg <= 1'b0;
      clk_b_reg <= 1'b0;
      run_b_reg <= 1'b0;
      aux_clk_reg <= 1'b0;
      aux_cnt_reg <= 2'h0;
      tick_cnt_reg <= 4'h0;
      b_seen_reg <= 1'b0;
      ready_reg <= 1'b0;
      pin_o_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else begin
      clk_a_reg <= clk_a_next;
      run_a_reg <= run_a_next;
      clk_b_reg <= clk_b_next;
      run_b_reg <= run_b_next;
      aux_clk_reg <= aux_clk_next;
      aux_cnt_reg <= aux_cnt_next;
      tick_cnt_reg <= tick_cnt_next;
      b_seen_reg <= b_seen_next;
      ready_reg <= ready_next;
      pin_o_reg <= pin_o_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  // Pin drive; a stopped clock sits low, or floats when its disable bit is set
  assign ctrl_pin_o = pin_o_reg;
  assign ctrl_pin_oe = pin_oe_reg;
  assign first_clock_output_o = clk_a_reg;
  assign first_clock_output_oe = run_a_reg || !dis_reg[coe_pkg::DIS_A_BIT];
  assign second_clock_output_o = clk_b_reg;
  assign second_clock_output_oe = run_b_reg || !dis_reg[coe_pkg::DIS_B_BIT];

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_mode_sample: assert property (state_reg == coe_pkg::ST_SAMPLE |=> serial_reg == !$past(mode_s2))
    else $error("mode not sampled");
  a_pin_ready: assert property (running && func == coe_pkg::FN_READY |=> ctrl_pin_oe)
    else $error("ready pin not driven");
  a_aux_edge: assert property ($changed(aux_clk_reg) && $past(func == coe_pkg::FN_AUX) |-> $past(aux_tick))
    else $error("aux edge without tick");
  a_out_start: assert property ($rose(clk_a_reg) |-> $past(want_a))
    else $error("output started while disabled");
  a_pol_low: assert property (running && oe_reg[coe_pkg::POL_BIT] && en_s2 && !clk_a_reg
                              |=> !clk_a_reg)
    else $error("active low pin high did not stop output");
  a_sync_edge: assert property ($changed(clk_b_reg) |-> $past(fractional_divider_b_tick))
    else $error("output edge off divider tick");
  a_dis_state: assert property (!run_a_reg |-> !first_clock_output_o
                                && (first_clock_output_oe != dis_reg[coe_pkg::DIS_A_BIT]))
    else $error("disabled output wrong");
  a_en_load: assert property (state_reg == coe_pkg::ST_LOAD |=> oe_reg[coe_pkg::EN_A_BIT]
                              && oe_reg[coe_pkg::EN_B_BIT])
    else $error("enables not loaded");
  a_serial_page: assert property (state_reg == coe_pkg::ST_SAMPLE && !mode_s2 |=> page_reg == 2'h0)
    else $error("serial mode page not zero");
  a_ro_bits: assert property (wr_fire && aw_addr_reg == coe_pkg::ADR_OE |=> !oe_reg[7])
    else $error("read-only bit written");
  a_bus_answer: assert property (wr_fire |=> bvalid)
    else $error("write not answered");
  a_ready_late: assert property (ready_reg |-> running && tick_cnt_reg == coe_pkg::READY_TICKS)
    else $error("ready too early");
  c_both_run: cover property (run_a_reg && run_b_reg);
  c_ready: cover property ($rose(ready_reg));
  c_aux: cover property (running && func == coe_pkg::FN_AUX && $rose(aux_clk_reg));
  c_hiz: cover property (!first_clock_output_oe);
endmodule // coe_clock_output_ctrl
`default_nettype wire

//--- bench/coe_host_model.sv
// Purpose: register host model driving the AXI4-Lite side
// Assumes: one write and one read at a time, data in the low half
// Notes: the low half is written as given, reserved bits included; the upper half is zero
`timescale 1ns/1ps
`default_nettype none
module coe_host_model (
  // Clock
  input wire logic ref_clk,
  // Write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // Idle bus from time zero
  initial begin
    {awaddr, araddr} = 16'h0000;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
  end

  // One word write, each channel held until taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] resp);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // One word read, address held until taken
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic [1:0] resp);
    @(posedge ref_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata[15:0];
    resp = rresp;
    rready <= 1'b0;
  endtask
endmodule // coe_host_model
`default_nettype wire

//--- bench/tb_clock_output_enable_control.sv
// Purpose: self-checking bench for the clock output enable control
// Assumes: both divider ticks every four cycles, offset in phase
// Notes: a floating enable pin is modelled by its active pull
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    n_tests++; \
    if ((gt) !== (ex)) begin \
      miscompares++; \
      $display("mismatch %s exp %0h got %0h", nm, ex, gt); \
    end \
  end
module tb_clock_output_enable_control;
  // Clock, reset, straps and pins
  logic ref_clk, rstn, ctrl_strap, oe_pin, oe_float, tick_a, tick_b, hi_last;
  logic [1:0] page_sel, fmt_strap, rs;
  logic [3:0] tick_cnt;
  logic [15:0] d;
  wire ctrl_pin_i, oe_pin_i;
  // Bus nets
  wire [7:0] awaddr, araddr;
  wire [31:0] wdata, rdata;
  wire [3:0] wstrb;
  wire [1:0] bresp, rresp;
  wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  // Design outputs
  wire ctrl_pin_o, ctrl_pin_oe, pu, pd, oa, oa_oe, ob, ob_oe, smode;
  wire [2:0] fa, fb;
  wire [1:0] sa, sb;
  wire [6:0] badr;
  int miscompares, n_tests, short_hi, hi_len, ta, tbb, tc;
  // Rows of {pin, polarity, enable, running}
  logic [3:0] rows [8] = '{4'hC, 4'hE, 4'h4, 4'h7, 4'h8, 4'hB, 4'h0, 4'h2};

  coe_clock_output_ctrl dut (.ref_clk(ref_clk), .rstn(rstn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .fractional_divider_a_tick(tick_a),
    .fractional_divider_b_tick(tick_b), .ctrl_pin_i(ctrl_pin_i), .ctrl_pin_o(ctrl_pin_o),
    .ctrl_pin_oe(ctrl_pin_oe), .oe_pin_i(oe_pin_i), .oe_pull_up_en(pu), .oe_pull_down_en(pd),
    .page_select_pins(page_sel), .format_address_strap(fmt_strap),
    .first_clock_output_o(oa), .first_clock_output_oe(oa_oe), .second_clock_output_o(ob),
    .second_clock_output_oe(ob_oe), .format_a(fa), .slew_a(sa), .format_b(fb), .slew_b(sb),
    .serial_mode(smode), .bus_address(badr));

  coe_host_model host (.ref_clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // Shared pin levels from every driver
  assign ctrl_pin_i = ctrl_pin_oe ? ctrl_pin_o : ctrl_strap;
  assign oe_pin_i = oe_float ? pu : oe_pin;

  // Clock, 25 ns period
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Divider ticks, same rate, different phase
  always @(posedge ref_clk) begin
    tick_cnt <= tick_cnt + 4'h1;
    tick_a <= (tick_cnt[1:0] == 2'h3);
    tick_b <= (tick_cnt[1:0] == 2'h1);
  end

  // High pulses shorter than a tick period are glitches
  always @(negedge ref_clk) begin
    if (oa !== hi_last) begin
      if (hi_last === 1'b1 && hi_len < 4 && rstn === 1'b1) short_hi++;
      hi_len = 0;
    end
    hi_len++;
    hi_last = oa;
  end

  task automatic reset_dut(input logic s, input logic [1:0] pg, input logic [1:0] fs);
    rstn <= 1'b0;
    ctrl_strap <= s;
    page_sel <= pg;
    fmt_strap <= fs;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (30) @(posedge ref_clk);
  endtask

  // Settle, then count toggles of both outputs and the pin
  task automatic observe(output int na, output int nb, output int nc);
    logic la, lb, lc;
    na = 0;
    nb = 0;
    nc = 0;
    repeat (40) @(posedge ref_clk);
    @(negedge ref_clk);
    {la, lb, lc} = {oa, ob, ctrl_pin_o};
    repeat (64) begin
      @(negedge ref_clk);
      if (oa !== la) na++;
      if (ob !== lb) nb++;
      if (ctrl_pin_o !== lc) nc++;
      {la, lb, lc} = {oa, ob, ctrl_pin_o};
    end
    // Back on a rising edge so later stimulus follows the clock
    @(posedge ref_clk);
  endtask

  task automatic end_test(input string nm);
    $display("test %s done, %0d checks so far", nm, n_tests);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (12000) @(posedge ref_clk);
    miscompares++;
    $display("timeout");
    finish_test();
  end

  // Main sequence
  initial begin
    {rstn, oe_pin, oe_float, ctrl_strap, tick_a, tick_b, hi_last} = 7'h10;
    {page_sel, fmt_strap, tick_cnt} = 8'h20;
    {miscompares, n_tests, short_hi, hi_len} = '0;
    @(posedge ref_clk);
    reset_dut(1'b0, 2'h0, 2'h2);
    host.rd(coe_pkg::ADR_OE, d, rs);
    `CHK("oe reg reset", 16'h6103, d)
    host.rd(coe_pkg::ADR_DIS, d, rs);
    `CHK("disable reg reset", 16'h0000, d)
    host.rd(coe_pkg::ADR_FMT, d, rs);
    `CHK("format reg reset", 16'h0000, d)
    `CHK("serial mode", 1'b1, smode)
    `CHK("bus address", {coe_pkg::DEV_ADDR_HI, 2'h2}, badr)
    observe(ta, tbb, tc);
    `CHK("float runs a", 1'b1, ta != 0)
    `CHK("float runs b", 1'b1, tbb != 0)
    `CHK("ready pin", 1'b1, ctrl_pin_o)
    end_test("reset");
    oe_float <= 1'b0;
    host.wr(coe_pkg::ADR_DIS, 16'h0060, rs);
    foreach (rows[i]) begin
      oe_pin <= rows[i][3];
      host.wr(coe_pkg::ADR_OE, {7'h30, rows[i][1], 6'h00, rows[i][1], rows[i][2]}, rs);
      observe(ta, tbb, tc);
      `CHK("runs a", rows[i][0], ta != 0)
      `CHK("runs b", rows[i][0], tbb != 0)
      `CHK("drive a", rows[i][0], oa_oe)
      `CHK("drive b", rows[i][0], ob_oe)
      `CHK("pull up", ~rows[i][2], pu)
      `CHK("pull down", rows[i][2], pd)
    end
    host.wr(coe_pkg::ADR_DIS, 16'h0000, rs);
    observe(ta, tbb, tc);
    `CHK("off drives a", 1'b1, oa_oe)
    `CHK("off low a", 1'b0, oa)
    `CHK("off quiet a", 1'b1, ta == 0)
    end_test("enable table");
    oe_pin <= 1'b0;
    host.wr(coe_pkg::ADR_OE, 16'h617F, rs);
    `CHK("format b", 3'h7, fb)
    `CHK("slew b", 2'h3, sb)
    host.wr(coe_pkg::ADR_FMT, 16'h0018, rs);
    `CHK("slew a", 2'h3, sa)
    `CHK("format a", 3'h0, fa)
    host.wr(coe_pkg::ADR_STAT, 16'hFFFF, rs);
    `CHK("status write resp", coe_pkg::RESP_OKAY, rs)
    host.rd(coe_pkg::ADR_STAT, d, rs);
    `CHK("status address", {coe_pkg::DEV_ADDR_HI, 2'h2}, d[14:8])
    host.rd(8'h20, d, rs);
    `CHK("unmapped read resp", coe_pkg::RESP_SLVERR, rs)
    `CHK("unmapped read data", 16'h0000, d)
    host.wr(8'h24, 16'h0001, rs);
    `CHK("unmapped write resp", coe_pkg::RESP_SLVERR, rs)
    end_test("registers");
    for (int f = 0; f < 4; f++) begin
      host.wr(coe_pkg::ADR_OE, {1'b0, 2'(f), 13'h0103}, rs);
      observe(ta, tbb, tc);
      `CHK("pin drive", f != 1, ctrl_pin_oe)
      `CHK("pin toggles", f == 2, tc != 0)
      if (f != 2) `CHK("pin level", f == 3, ctrl_pin_o)
    end
    host.wr(coe_pkg::ADR_OE, 16'h4103, rs);
    for (int k = 0; k < 4; k++) begin
      host.wr(coe_pkg::ADR_AUX, (k == 3) ? 16'h0001 : 16'(2 * k), rs);
      observe(ta, tbb, tc);
      `CHK("aux rate", 1'b1, (tc - ((k == 3) ? 16 : (16 >> k))) inside {[-1:1]})
    end
    end_test("pin function");
    reset_dut(1'b1, 2'h3, 2'h1);
    `CHK("page mode", 1'b0, smode)
    `CHK("page bus address", {coe_pkg::DEV_ADDR_HI, 2'h1}, badr)
    host.rd(coe_pkg::ADR_OE, d, rs);
    `CHK("page oe reg", 16'h6103, d)
    host.rd(coe_pkg::ADR_STAT, d, rs);
    `CHK("page select", 2'h3, d[3:2])
    `CHK("short pulses", 0, short_hi)
    end_test("page mode");
    finish_test();
  end
endmodule // tb_clock_output_enable_control
`default_nettype wire
